// ---- rtl/code_pick.sv ----
// priority picker: lowest set event bit becomes base plus index
`timescale 1ns/1ps
module code_pick #(
   parameter int         WIDTH = 10,
   parameter logic [7:0] BASE  = 8'h01
) (
   input  wire logic [WIDTH-1:0] events,
   output logic                  hit,
   output logic [7:0]            code
);
   if (WIDTH < 1 || int'(BASE) + WIDTH > 256) begin : g_bad
      $error("code_pick: code range exceeds one byte");
   end
   // scan downward so the lowest index wins
   always_comb begin
      hit  = |events;
      code = BASE;
      for (int i = WIDTH - 1; i >= 0; i--) begin
         if (events[i]) begin
            code = BASE + 8'(i);
         end
      end
   end
endmodule // code_pick

// ---- rtl/code_xlate_rom.sv ----
// internal error code to host detail code table, registered read
`timescale 1ns/1ps
module code_xlate_rom #(
   parameter bit LEGACY_94_95 = 1'b0
) (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       rd_en,
   input  wire logic [7:0] addr,
   output logic [7:0]      data_q
);
   logic [7:0] data_d;
   // every internal code lands on exactly one host code
   always_comb begin
      case (addr) inside
         8'h00: data_d = 8'h00;
         8'h01: data_d = 8'h06;
         8'h02: data_d = 8'h0B;
         8'h0A: data_d = 8'h09;
         8'h0B: data_d = 8'h0A;
         8'h0C: data_d = 8'h10;
         8'h0D: data_d = 8'h13;
         8'h10, 8'h11, 8'hF0: data_d = 8'h18;
         8'h16: data_d = 8'h07;
         8'h18: data_d = 8'h1F;
         8'hF1: data_d = 8'h21;
         8'h22, 8'h23, 8'h24, 8'h42, 8'h43: data_d = 8'h2D;
         [8'h51:8'h5A]: data_d = 8'h2F;
         8'h5E, 8'h5F: data_d = LEGACY_94_95 ? 8'hFE : 8'h2F;
         8'h31, 8'h5B: data_d = 8'h30;
         8'h2C, 8'h32, 8'h4C: data_d = 8'h31;
         8'h21, 8'h2D, 8'h41, 8'h4D: data_d = 8'h33;
         [8'h25:8'h27], [8'h45:8'h47]: data_d = 8'h35;
         8'h76: data_d = 8'h37;
         8'h44: data_d = 8'h3B;
         8'h20: data_d = 8'h3C;
         8'h2B, 8'h2F, 8'h4B: data_d = 8'h3D;
         8'h33: data_d = 8'h3F;
         8'h62: data_d = 8'h52;
         8'h60, 8'h74: data_d = 8'h53;
         8'h2E, 8'h30, 8'h4E, 8'h4F: data_d = 8'h58;
         8'h78: data_d = 8'h5A;
         8'h61: data_d = 8'h5B;
         8'h34, 8'h35, [8'h7D:8'h7F]: data_d = 8'h5E;
         [8'h6E:8'h73]: data_d = 8'h5F;
         8'h2A, 8'h4A: data_d = 8'h66;
         8'h50: data_d = 8'h68;
         8'h5D: data_d = 8'h69;
         8'hA6: data_d = 8'h7B;
         8'hA5: data_d = 8'h7D;
         8'h5C, 8'hA0, 8'hA1, 8'hDC: data_d = 8'h81;
         8'h40: data_d = 8'h82;
         8'hA2: data_d = 8'h83;
         8'h19, 8'h1A, 8'hA3, 8'hA4: data_d = 8'h8C;
         8'h80: data_d = 8'h8D;
         8'hA8: data_d = 8'h96;
         [8'hA9:8'hAF]: data_d = 8'h97;
         [8'hB0:8'hB6]: data_d = 8'h98;
         8'hC0: data_d = 8'hA2;
         8'hC5: data_d = 8'hA7;
         8'hC6: data_d = 8'hA8;
         8'hC8: data_d = 8'hAA;
         8'hCC: data_d = 8'hAE;
         8'hCD: data_d = 8'hAF;
         8'hCE: data_d = 8'hB0;
         8'hD0: data_d = 8'hB2;
         8'hD2: data_d = 8'hB4;
         8'hD3: data_d = 8'hB5;
         8'hD6: data_d = 8'hB8;
         8'hD7: data_d = 8'hB9;
         8'hDA: data_d = 8'hBC;
         8'hDB: data_d = 8'hBD;
         8'h03, 8'h05, [8'h07:8'h09], 8'h0E, [8'h12:8'h15], 8'h17,
         [8'h1C:8'h1F], 8'h75: data_d = 8'hFF;
         default: data_d = 8'hFE;
      endcase
   end
   // read data held in a register, zero maps to zero at reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         data_q <= 8'h00;
      end else if (rd_en) begin
         data_q <= data_d;
      end
   end
   // checks on fixed rows of the table
   a_xlate_fixed: assert property (
      @(posedge clock) disable iff (!rst_b)
      rd_en && addr inside {[8'h51:8'h5A]} |=> data_q == 8'h2F)
      else $error("write verify failure not 47");
   a_xlate_other: assert property (
      @(posedge clock) disable iff (!rst_b)
      rd_en && addr inside {8'h03, 8'h75} |=> data_q == 8'hFF ##1
      ($past(rd_en) || data_q == 8'hFF))
      else $error("listed internal code not 255");
endmodule // code_xlate_rom

// ---- rtl/tape_error_status_mapper.sv ----
// error detail and back-reference status bytes of the tape drive
`timescale 1ns/1ps
`include "tape_err_defs.svh"
// Overview of operation
// - formatter flag loads code 101 to 110
// - flux during erase reports 104
// - stalled or unstarted gap timer reports 109
// - controller flag loads code 121 to 152
// - report overflow 124, command overflow 126
// - buffer faults report 128, 129, 130, 131
// - protocol reject loads code 161 to 189
// - busy command queue rejects with 161
// - missing end marker rejects with 168
// - device clear code never reaches host
// - reserved internal codes become 254
// - listed internal codes become 255
// - back-reference only in immediate mode
// - count commands reported since failing write
// - hard error aborts every later command until status is read
// - internal 81 to 90 become 47
// - internal 169 to 175 become 151
// - internal 176 to 182 become 152
// - internal 94 and 95 become 47, or 254 with LEGACY_94_95 set
// - status report carries host codes only
// - table total, internal zero gives zero
// - error class encodings 0, 2, 3, 7
module tape_error_status_mapper
   import tape_err_pkg::*;
#(
   parameter int GAP_STALL_CYCLES = `GAP_STALL_CYCLES,
   parameter int COUNT_WIDTH      = 16,
   parameter bit LEGACY_94_95     = 1'b0
) (
   input  wire logic                   clock,
   input  wire logic                   rst_b,
   input  wire status_flags_type       flags,
   input  wire logic                   erase_active,
   input  wire logic                   flux_sensed,
   input  wire logic                   gap_wait,
   input  wire logic                   gap_timer_run,
   input  wire logic [7:0]             gap_timer_value,
   input  wire logic [9:0]             fmt_other,
   input  wire ctrl_fault_type         ctrl_fault,
   input  wire logic                   record_done,
   input  wire logic [COUNT_WIDTH-1:0] put_count,
   input  wire logic [COUNT_WIDTH-1:0] remove_count,
   input  wire logic [31:0]            ctrl_other,
   input  wire logic                   cmd_request,
   input  wire logic [3:0]             queue_entries,
   input  wire logic                   data_end,
   input  wire logic                   eoi_seen,
   input  wire logic                   device_clear,
   input  wire logic [29:0]            prot_other,
   input  wire logic                   internal_valid,
   input  wire logic [7:0]             internal_error_code,
   input  wire logic                   status_read,
   input  wire logic                   immediate_mode,
   input  wire logic                   imm_write_issued,
   input  wire logic                   imm_write_done,
   input  wire logic                   imm_write_error,
   input  wire logic                   imm_write_hard,
   input  wire logic                   cmd_reported,
   output logic                        busy_reject,
   output logic                        eoi_reject,
   output logic                        abort_commands,
   output logic [7:0]                  error_detail_code,
   output logic [7:0]                  back_reference_count
);
   if (GAP_STALL_CYCLES < 2 || GAP_STALL_CYCLES > 65535) begin : g_bad
      $error("gap stall count out of range");
   end
   if (COUNT_WIDTH < 1 || COUNT_WIDTH > 32) begin : g_bad_w
      $error("byte count width out of range");
   end
   logic [`FMT_EVT_WIDTH-1:0]  fmt_evt;
   logic [`CTRL_EVT_WIDTH-1:0] ctrl_evt;
   logic [`PROT_EVT_WIDTH-1:0] prot_evt;
   logic                       fmt_hit, ctrl_hit, prot_hit;
   logic [7:0]                 fmt_code, ctrl_code, prot_code;
   logic [7:0]                 fmt_code_q, ctrl_code_q, prot_code_q;
   logic                       fmt_hit_q, ctrl_hit_q, prot_hit_q;
   logic [15:0]                stall_q;
   logic [7:0]                 gap_prev_q;
   logic                       gap_fault_q;
   logic                       gap_fault;
   logic                       erase_fault;
   logic                       count_mismatch;
   logic [7:0]                 xlate_code;
   logic [7:0]                 detail_d;
   logic [7:0]                 error_detail_code_q;
   backref_state_type          br_state_q;
   logic [7:0]                 br_count_q;
   logic [7:0]                 back_reference_count_q;
   logic                       abort_q;
   // erase head picks up flux where the tape should be blank
   assign erase_fault = erase_active && flux_sensed;
   // gap timer watch: not running, or value frozen, while a gap is due
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         stall_q     <= 16'h0000;
         gap_prev_q  <= 8'h00;
         gap_fault_q <= 1'b0;
      end else begin
         gap_prev_q <= gap_timer_value;
         if (!gap_wait) begin
            stall_q     <= 16'h0000;
            gap_fault_q <= 1'b0;
         end else if (gap_timer_run &&
                      gap_timer_value != gap_prev_q) begin
            stall_q <= 16'h0000;
         end else if (!gap_fault_q) begin
            stall_q <= stall_q + 16'h0001;
            if (stall_q == 16'(GAP_STALL_CYCLES - 1)) begin
               gap_fault_q <= 1'b1;
            end
         end
      end
   end
   // single pulse when the watch trips
   assign gap_fault = gap_wait && !gap_fault_q &&
                      stall_q == 16'(GAP_STALL_CYCLES - 1) &&
                      !(gap_timer_run && gap_timer_value != gap_prev_q);
   // put and remove byte counts of one record must agree
   assign count_mismatch = record_done && (put_count != remove_count);
   // formatter events, code = base plus bit index
   always_comb begin
      fmt_evt                 = fmt_other;
      fmt_evt[`FMT_BIT_ERASE] = fmt_other[`FMT_BIT_ERASE] || erase_fault;
      fmt_evt[`FMT_BIT_GAP]   = fmt_other[`FMT_BIT_GAP] || gap_fault;
   end
   // controller events with the named faults merged in
   always_comb begin
      ctrl_evt = ctrl_other;
      ctrl_evt[`CTRL_BIT_RPT_OVF] |= ctrl_fault.report_q_ovf;
      ctrl_evt[`CTRL_BIT_CMD_OVF] |= ctrl_fault.cmd_q_ovf;
      ctrl_evt[`CTRL_BIT_NO_EOR] |= ctrl_fault.missing_eor;
      ctrl_evt[`CTRL_BIT_PARITY] |= ctrl_fault.buf_parity;
      ctrl_evt[`CTRL_BIT_UNDERRUN] |= ctrl_fault.write_underrun;
      ctrl_evt[`CTRL_BIT_MISMATCH] |= count_mismatch;
   end
   // protocol rejects raised by this block
   assign busy_reject = cmd_request && (queue_entries != 4'h0);
   assign eoi_reject  = data_end && !eoi_seen;
   // protocol events; device clear stays internal
   always_comb begin
      prot_evt = prot_other;
      prot_evt[`PROT_BIT_BUSY] |= busy_reject;
      prot_evt[`PROT_BIT_NO_EOI] |= eoi_reject;
      prot_evt[`PROT_BIT_DEV_CLR] = 1'b0;
   end
   code_pick #(
      .WIDTH (`FMT_EVT_WIDTH),
      .BASE  (`FMT_CODE_BASE)
   ) u_fmt_pick (
      .events (fmt_evt),
      .hit    (fmt_hit),
      .code   (fmt_code)
   );
   code_pick #(
      .WIDTH (`CTRL_EVT_WIDTH),
      .BASE  (`CTRL_CODE_BASE)
   ) u_ctrl_pick (
      .events (ctrl_evt),
      .hit    (ctrl_hit),
      .code   (ctrl_code)
   );
   code_pick #(
      .WIDTH (`PROT_EVT_WIDTH),
      .BASE  (`PROT_CODE_BASE)
   ) u_prot_pick (
      .events (prot_evt),
      .hit    (prot_hit),
      .code   (prot_code)
   );
   // sticky per-class codes; a new event beats the read clear
   always_ff @(posedge clock) begin
      if (!rst_b || device_clear) begin
         fmt_code_q  <= `DETAIL_RESET;
         ctrl_code_q <= `DETAIL_RESET;
         prot_code_q <= `DETAIL_RESET;
         fmt_hit_q   <= 1'b0;
         ctrl_hit_q  <= 1'b0;
         prot_hit_q  <= 1'b0;
      end else begin
         if (fmt_hit) begin
            fmt_code_q <= fmt_code;
            fmt_hit_q  <= 1'b1;
         end else if (status_read) begin
            fmt_hit_q <= 1'b0;
         end
         if (ctrl_hit) begin
            ctrl_code_q <= ctrl_code;
            ctrl_hit_q  <= 1'b1;
         end else if (status_read) begin
            ctrl_hit_q <= 1'b0;
         end
         if (prot_hit) begin
            prot_code_q <= prot_code;
            prot_hit_q  <= 1'b1;
         end else if (status_read) begin
            prot_hit_q <= 1'b0;
         end
      end
   end
   // internal codes pass only through the translation table
   code_xlate_rom #(
      .LEGACY_94_95 (LEGACY_94_95)
   ) u_xlate (
      .clock  (clock),
      .rst_b  (rst_b),
      .rd_en  (internal_valid),
      .addr   (internal_error_code),
      .data_q (xlate_code)
   );
   // detail source chosen by the active status flags
   always_comb begin
      if (flags.controller_error && ctrl_hit_q) begin
         detail_d = ctrl_code_q;
      end else if (flags.formatter_error && fmt_hit_q) begin
         detail_d = fmt_code_q;
      end else if (flags.command_reject && prot_hit_q &&
                   flags.error_class == CLASS_PROTOCOL) begin
         detail_d = prot_code_q;
      end else begin
         detail_d = xlate_code;
      end
   end
   // detail status byte register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         error_detail_code_q <= `DETAIL_RESET;
      end else begin
         error_detail_code_q <= detail_d;
      end
   end
   assign error_detail_code = error_detail_code_q;
   // back-reference tracker for one immediate-reported write
   always_ff @(posedge clock) begin
      if (!rst_b || device_clear || !immediate_mode) begin
         br_state_q <= BR_IDLE;
         br_count_q <= 8'h00;
         abort_q    <= 1'b0;
      end else begin
         case (br_state_q)
            BR_IDLE: begin
               if (imm_write_issued) begin
                  br_state_q <= BR_TRACK;
                  br_count_q <= 8'h00;
               end
            end
            BR_TRACK: begin
               if (imm_write_error) begin
                  br_state_q <= BR_HELD;
                  abort_q    <= imm_write_hard;
               end else if (imm_write_done) begin
                  br_state_q <= BR_IDLE;
               end else if (cmd_reported && br_count_q != 8'hFF) begin
                  br_count_q <= br_count_q + 8'h01;
               end
            end
            BR_HELD: begin
               if (status_read) begin
                  br_state_q <= BR_IDLE;
                  abort_q    <= 1'b0;
               end
            end
            default: begin
               br_state_q <= BR_IDLE;
               abort_q    <= 1'b0;
            end
         endcase
      end
   end
   // count byte shows the captured count, zero outside immediate mode
   always_ff @(posedge clock) begin
      if (!rst_b || !immediate_mode) begin
         back_reference_count_q <= `BACKREF_RESET;
      end else if (br_state_q == BR_TRACK && imm_write_error) begin
         back_reference_count_q <= br_count_q;
      end
   end
   assign back_reference_count = back_reference_count_q;
   assign abort_commands       = abort_q;
   // checks on the mapping and the tracker
   a_fmt_range: assert property (
      @(posedge clock) disable iff (!rst_b)
      flags.formatter_error && !flags.controller_error && fmt_hit_q |=>
      error_detail_code >= `FMT_CODE_BASE &&
      error_detail_code <= `FMT_CODE_LAST)
      else $error("formatter detail out of range");
   a_erase_code: assert property (
      @(posedge clock) disable iff (!rst_b)
      erase_fault && fmt_other[2:0] == 3'h0 && !device_clear |=>
      fmt_code_q == 8'h68 && fmt_hit_q)
      else $error("erase failure not coded 104");
   a_gap_stall: assert property (
      @(posedge clock) disable iff (!rst_b)
      gap_wait && !gap_fault_q && !gap_timer_run && fmt_evt[7:0] == 8'h00 &&
      stall_q == 16'(GAP_STALL_CYCLES - 1) && !device_clear |=>
      fmt_hit_q && fmt_code_q == 8'h6D)
      else $error("gap stall not reported");
   a_ctrl_range: assert property (
      @(posedge clock) disable iff (!rst_b)
      flags.controller_error && ctrl_hit_q |=>
      error_detail_code >= `CTRL_CODE_BASE &&
      error_detail_code <= `CTRL_CODE_LAST)
      else $error("controller detail out of range");
   a_queue_ovf: assert property (
      @(posedge clock) disable iff (!rst_b)
      ctrl_fault.cmd_q_ovf && ctrl_evt[4:0] == 5'h00 && !device_clear
      |=> ctrl_code_q == 8'h7E)
      else $error("command queue overflow not 126");
   a_buf_fault: assert property (
      @(posedge clock) disable iff (!rst_b)
      count_mismatch && ctrl_evt[9:0] == 10'h000 && !device_clear
      |=> ctrl_code_q == 8'h83)
      else $error("byte count mismatch not 131");
   a_prot_range: assert property (
      @(posedge clock) disable iff (!rst_b)
      prot_hit_q && !flags.controller_error &&
      !flags.formatter_error && flags.command_reject &&
      flags.error_class == CLASS_PROTOCOL |=>
      error_detail_code >= `PROT_CODE_BASE &&
      error_detail_code <= `PROT_CODE_LAST)
      else $error("protocol detail out of range");
   a_busy_reject: assert property (
      @(posedge clock) disable iff (!rst_b)
      cmd_request && queue_entries != 4'h0 && !device_clear |->
      busy_reject ##1 prot_code_q == `CODE_BUSY)
      else $error("busy queue not rejected with 161");
   a_eoi_reject: assert property (
      @(posedge clock) disable iff (!rst_b)
      eoi_reject && prot_other[6:0] == 7'h00 && !busy_reject &&
      !device_clear |=> prot_code_q == `CODE_NO_EOI)
      else $error("missing end marker not 168");
   a_no_dev_clear: assert property (
      @(posedge clock) disable iff (!rst_b)
      error_detail_code != `CODE_DEV_CLEAR)
      else $error("device clear code reached host");
   a_backref_mode: assert property (
      @(posedge clock) disable iff (!rst_b)
      !immediate_mode |=> back_reference_count == 8'h00 &&
      !abort_commands)
      else $error("back-reference used outside immediate mode");
   a_backref_step: assert property (
      @(posedge clock) disable iff (!rst_b)
      br_state_q == BR_TRACK && cmd_reported && !imm_write_error &&
      !imm_write_done && immediate_mode && !device_clear &&
      br_count_q != 8'hFF |=> br_count_q == $past(br_count_q) + 8'h01)
      else $error("reported command not counted");
   a_hard_abort: assert property (
      @(posedge clock) disable iff (!rst_b)
      br_state_q == BR_TRACK && imm_write_error && imm_write_hard &&
      immediate_mode && !device_clear |=> abort_commands &&
      back_reference_count == $past(br_count_q))
      else $error("hard error did not abort later commands");
   c_fmt_seen: cover property (
      @(posedge clock) disable iff (!rst_b)
      fmt_hit ##1 flags.formatter_error);
   c_hard_held: cover property (
      @(posedge clock) disable iff (!rst_b)
      br_state_q == BR_TRACK ##1 br_state_q == BR_HELD && abort_q);
   c_busy: cover property (
      @(posedge clock) disable iff (!rst_b) busy_reject);
   c_xlate: cover property (
      @(posedge clock) disable iff (!rst_b)
      internal_valid ##1 xlate_code == 8'h97);
endmodule // tape_error_status_mapper

// ---- shared/tape_err_defs.svh ----
// code values, field positions and timing counts for the error mapper
`ifndef TAPE_ERR_DEFS_SVH
`define TAPE_ERR_DEFS_SVH
`define CLOCK_MHZ        25
`define FMT_CODE_BASE    8'h65
`define FMT_CODE_LAST    8'h6E
`define FMT_EVT_WIDTH    10
`define FMT_BIT_ERASE    3
`define FMT_BIT_GAP      8
`define CTRL_CODE_BASE   8'h79
`define CTRL_CODE_LAST   8'h98
`define CTRL_EVT_WIDTH   32
`define CTRL_BIT_RPT_OVF 3
`define CTRL_BIT_CMD_OVF 5
`define CTRL_BIT_NO_EOR  7
`define CTRL_BIT_PARITY  8
`define CTRL_BIT_UNDERRUN 9
`define CTRL_BIT_MISMATCH 10
`define PROT_CODE_BASE   8'hA1
`define PROT_CODE_LAST   8'hBE
`define PROT_EVT_WIDTH   30
`define PROT_BIT_BUSY    0
`define PROT_BIT_NO_EOI  7
`define PROT_BIT_DEV_CLR 29
`define CODE_BUSY        8'hA1
`define CODE_NO_EOI      8'hA8
`define CODE_DEV_CLEAR   8'hBE
`define DETAIL_RESET     8'h00
`define BACKREF_RESET    8'h00
`define GAP_STALL_US     100
`define GAP_STALL_CYCLES (`GAP_STALL_US * `CLOCK_MHZ)
`endif

// ---- shared/tape_err_pkg.sv ----
// types shared by the error detail mapper
package tape_err_pkg;
   // error class field of the reject status byte
   typedef enum logic [2:0] {
      CLASS_NONE     = 3'h0,
      CLASS_DEVICE   = 3'h2,
      CLASS_PROTOCOL = 3'h3,
      CLASS_SELFTEST = 3'h7
   } error_class_type;
   // status flags that choose the detail source
   typedef struct packed {
      logic            controller_error;
      logic            formatter_error;
      logic            command_reject;
      error_class_type error_class;
   } status_flags_type;
   // named controller faults
   typedef struct packed {
      logic report_q_ovf;
      logic cmd_q_ovf;
      logic missing_eor;
      logic buf_parity;
      logic write_underrun;
   } ctrl_fault_type;
   // back-reference tracker, gray along idle-track-held
   typedef enum logic [1:0] {
      BR_IDLE  = 2'h0,
      BR_TRACK = 2'h1,
      BR_HELD  = 2'h3
   } backref_state_type;
endpackage

// ---- tb/status_host.sv ----
// host model that reads the detail status byte one cycle at a time
`timescale 1ns/1ps
module status_host (
   input  wire logic       clock,
   input  wire logic [7:0] detail,
   output logic            status_read
);
   initial status_read = 1'h0;
   // one-cycle read strobe, detail byte taken while it stands
   task automatic read_status(output logic [7:0] v);
      @(negedge clock);
      status_read = 1'h1;
      v = detail;
      @(negedge clock);
      status_read = 1'h0;
   endtask
endmodule // status_host

// ---- tb/test_tape_error_status_mapper.sv ----
// self-checking bench for the error detail mapper
`timescale 1ns/1ps
module test_tape_error_status_mapper import tape_err_pkg::*;;
   logic clock = '0, rst_b = '0, erase_active = '0, flux_sensed = '0,
      gap_wait = '0, record_done = '0, cmd_request = '0, data_end = '0,
      eoi_seen = '0, device_clear = '0, internal_valid = '0,
      immediate_mode = '0, imm_write_issued = '0, imm_write_done = '0,
      imm_write_error = '0, imm_write_hard = '0, cmd_reported = '0;
   status_flags_type flags = '0;
   ctrl_fault_type   ctrl_fault = '0;
   logic [3:0]  queue_entries = '0;
   logic [7:0]  internal_error_code = '0, seen, gap_timer_value = '0;
   logic        gap_timer_run = '0;
   logic [15:0] put_count = 16'h0005, remove_count = 16'h0005;
   logic        status_read, busy_reject, eoi_reject, abort_commands;
   logic [7:0]  error_detail_code, back_reference_count;
   int          errors = 0, num_checks = 0;
   always #20 clock = ~clock;
   // design with a short gap stall count
   tape_error_status_mapper #(.GAP_STALL_CYCLES(10)) dut (.clock, .rst_b,
      .flags, .erase_active, .flux_sensed, .gap_wait, .gap_timer_run,
      .gap_timer_value, .fmt_other(10'h000), .ctrl_fault,
      .record_done, .put_count, .remove_count, .ctrl_other(32'h0),
      .cmd_request, .queue_entries, .data_end, .eoi_seen, .device_clear,
      .prot_other(30'h0), .internal_valid, .internal_error_code,
      .status_read, .immediate_mode, .imm_write_issued, .imm_write_done,
      .imm_write_error, .imm_write_hard, .cmd_reported, .busy_reject,
      .eoi_reject, .abort_commands, .error_detail_code, .back_reference_count);
   status_host host (.clock, .detail(error_detail_code), .status_read);
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   // each controller fault in turn, then a put/remove count mismatch
   task automatic t_ctrl;
      logic [7:0] exp [5] = '{8'h7C, 8'h7E, 8'h80, 8'h81, 8'h82};
      flags = '{1'h1, 1'h0, 1'h0, CLASS_NONE};
      for (int i = 0; i < 5; i++) begin
         ctrl_fault = 5'h10 >> i; step(1); ctrl_fault = '0; step(2);
         check(error_detail_code, exp[i]);
      end
      remove_count = 16'h0004; record_done = 1'h1; step(1);
      record_done = 1'h0; step(2);
      check(error_detail_code, 8'h83);
      $display("controller test done");
   endtask
   // flux during erase, then a gap timer that runs and then stops
   task automatic t_fmt;
      flags = '{1'h0, 1'h1, 1'h0, CLASS_NONE};
      erase_active = 1'h1; flux_sensed = 1'h1; step(1);
      erase_active = 1'h0; flux_sensed = 1'h0; step(2);
      check(error_detail_code, 8'h68);
      gap_wait = 1'h1; gap_timer_run = 1'h1;
      repeat (14) begin
         gap_timer_value--; step(1);
      end
      check(error_detail_code, 8'h68);
      gap_timer_run = 1'h0; step(14); gap_wait = 1'h0;
      check(error_detail_code, 8'h6D);
      $display("formatter test done");
   endtask
   // busy queue and missing end marker under a protocol reject
   task automatic t_prot;
      flags = '{1'h0, 1'h0, 1'h1, CLASS_PROTOCOL};
      queue_entries = 4'h2; cmd_request = 1'h1; #1;
      check({7'h00, busy_reject}, 8'h01);
      step(1); cmd_request = 1'h0; step(2);
      check(error_detail_code, 8'hA1);
      data_end = 1'h1; eoi_seen = 1'h1; #1;
      check({7'h00, eoi_reject}, 8'h00);
      step(1); eoi_seen = 1'h0; #1;
      check({7'h00, eoi_reject}, 8'h01);
      step(1); data_end = 1'h0; step(2);
      check(error_detail_code, 8'hA8);
      flags.error_class = CLASS_DEVICE; step(2);
      check(error_detail_code, 8'h00);
      $display("protocol test done");
   endtask
   // internal codes through the table, read back by the host
   task automatic t_xlate;
      logic [15:0] tbl [7] = '{16'hA997, 16'hB098, 16'h512F, 16'h5E2F,
         16'h03FF, 16'h64FE, 16'h0000};
      flags = '0;
      for (int i = 0; i < 7; i++) begin
         internal_error_code = tbl[i][15:8]; internal_valid = 1'h1; step(1);
         internal_valid = 1'h0; step(2);
         host.read_status(seen);
         check(seen, tbl[i][7:0]);
      end
      $display("translation test done");
   endtask
   // two commands reported after an immediate write, then a hard error
   task automatic t_backref;
      immediate_mode = 1'h1; imm_write_issued = 1'h1; step(1);
      imm_write_issued = 1'h0; cmd_reported = 1'h1; step(2);
      cmd_reported = 1'h0; imm_write_error = 1'h1; imm_write_hard = 1'h1;
      step(1); imm_write_error = 1'h0; imm_write_hard = 1'h0; step(1);
      check(back_reference_count, 8'h02);
      check({7'h00, abort_commands}, 8'h01);
      host.read_status(seen); step(1);
      check({7'h00, abort_commands}, 8'h00);
      immediate_mode = 1'h0; step(2);
      check(back_reference_count, 8'h00);
      $display("back reference test done");
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // reset, then every scenario in turn
   initial begin
      step(3); rst_b = 1'h1;
      t_ctrl; t_fmt; t_prot; t_xlate; t_backref;
      print_verdict;
   end
   // cut a hang short
   initial begin
      #1000000; errors++;
      print_verdict;
   end
endmodule // test_tape_error_status_mapper
